// ===== bench/ext_mem_model.sv
// Far side of the bus: a clocked address latch, loaded at clock edges while ale_i is high, and a byte memory.
// Assumes Port 0 has no pull-up: undriven bits toggle every cycle.
`timescale 1ns/100ps
module ext_mem_model (
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic       psen_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] p0_drv_i,
  input  wire logic [7:0] p0_oe_i,
  input  wire logic [7:0] p2_i,
  output logic      [7:0] p0_pin_o
);
  logic [7:0]  lat_r = 8'h00;
  logic [7:0]  last_r = 8'h00;
  logic [7:0]  mem [int];
  logic [15:0] addr;
  logic [7:0]  rd_byte;

  assign addr = {p2_i, lat_r};

  always @(posedge clk_i) begin
    if (ale_i) lat_r <= p0_pin_o;
    if (!wr_n_i) mem[addr] = p0_pin_o;
    last_r <= p0_pin_o;
  end

  // Unwritten places answer a pattern of their address
  always @* begin
    rd_byte = mem.exists(addr) ? mem[addr] : addr[7:0] ^ addr[15:8] ^ 8'hA5;
    for (int i = 0; i < 8; i++) begin
      if (p0_oe_i[i]) p0_pin_o[i] = p0_drv_i[i];
      else if (!rd_n_i || !psen_n_i) p0_pin_o[i] = rd_byte[i];
      else p0_pin_o[i] = ~last_r[i];
    end
  end
endmodule

// ===== bench/external_memory_bus_interface_tb.sv
// Self-checking bench: Wishbone master, core requests, pin monitor.
// Assumes ext_mem_model on the far side of Port 0 and Port 2.
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module external_memory_bus_interface_tb;
  import ext_bus_pkg::*;
  logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, req_i, req_we_i;
  logic         done_o, pointer_toggle_i, ale_o, psen_n_o, wr_n_o, rd_n_o;
  logic         ale_q, rd_s, wr_s, ps_s, w;
  logic [9:0]   wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o;
  logic [15:0]  req_addr_i, data_pointer_o, ea;
  logic [7:0]   req_ri_i, req_wdata_i, rdata_o, p0_i, p0_o, p0_oe_o, p2_o;
  logic [7:0]   cap_lo, cap_oe, cap_p2, q, d;
  logic [7:0]   sh [int];
  logic [15:0]  eas [12];
  access_kind_e req_kind_i, k;
  int           err_total, checks, ale_n, base, n, r;

  external_memory_bus_interface u_external_memory_bus_interface (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .req_i, .req_kind_i, .req_we_i, .req_addr_i, .req_ri_i,
    .req_wdata_i, .done_o, .rdata_o, .pointer_toggle_i, .data_pointer_o, .p0_i,
    .p0_o, .p0_oe_o, .p2_o, .ale_o, .psen_n_o, .wr_n_o, .rd_n_o);
  ext_mem_model u_ext_mem_model (
    .clk_i, .ale_i(ale_o), .psen_n_i(psen_n_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .p0_drv_i(p0_o), .p0_oe_i(p0_oe_o), .p2_i(p2_o), .p0_pin_o(p0_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Sees pre-edge values; the last strobe high before a data strobe marks the op
  always @(posedge clk_i) begin
    ale_q <= ale_o;
    if (ale_o && !ale_q) ale_n++;
    if (!rd_n_o) rd_s = 1'b1;
    if (!wr_n_o) wr_s = 1'b1;
    if (!psen_n_o) ps_s = 1'b1;
    if (ale_o && !(rd_s || wr_s || ps_s)) {cap_lo, cap_oe, cap_p2} = {p0_o, p0_oe_o, p2_o};
  end

  function automatic logic [7:0] expd(input logic [15:0] a);
    return sh.exists(a) ? sh[a] : a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] dat);
    int t;
    t = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, idx, 2'b00, 4'h1};
    wb_dat_i <= {24'h000000, dat};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && t++ < 20) @(posedge clk_i);
    `CHK(wb_ack_o, 1'b1)
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    wb(1'b1, idx, dat);
  endtask

  task automatic req(input access_kind_e kk, input logic we, input logic [15:0] a,
                     input logic [7:0] ri, input logic [7:0] dat);
    @(negedge clk_i);
    {rd_s, wr_s, ps_s} = 3'b000;
    ale_n = 0;
    @(posedge clk_i);
    req_kind_i <= kk;
    {req_i, req_we_i, req_addr_i, req_ri_i, req_wdata_i} <= {1'b1, we, a, ri, dat};
    n = 1;
    @(posedge clk_i);
    while (done_o !== 1'b1 && n++ < 40) @(posedge clk_i);
    `CHK(done_o, 1'b1)
    q = rdata_o;
    req_i <= 1'b0;
  endtask

  task automatic tog();
    @(posedge clk_i);
    pointer_toggle_i <= 1'b1;
    @(posedge clk_i);
    pointer_toggle_i <= 1'b0;
  endtask

  task automatic tdone(input string s);
    $display("test %s ended: checks %0d mismatches %0d", s, checks, err_total);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run is some 600 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {req_i, req_we_i, req_addr_i, req_ri_i, req_wdata_i, pointer_toggle_i} = '0;
    req_kind_i = ACC_FETCH;
    r = $urandom(32'h33b05c4d);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK(p0_oe_o, 8'h00)
    wb(1'b0, 8'h8E, 8'h00);
    `CHK(q[1:0], 2'b00)
    wb(1'b0, 8'hA2, 8'h00);
    `CHK(q[0], 1'b0)
    tdone("reset");
    for (int s = 0; s < 2; s++) begin
      wr(8'hC0, 8'(s));
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      base = ale_n;
      repeat (60) @(negedge clk_i);
      `CHK(ale_n - base, 10 * (s + 1))
    end
    wr(8'hC0, 8'h00);
    tdone("strobe rate");
    d = 8'($urandom);
    wr(8'h80, d);
    @(negedge clk_i);
    `CHK(p0_oe_o, ~d)
    `CHK(p0_o & p0_oe_o, 8'h00)
    wr(8'h80, 8'hFF);
    @(negedge clk_i);
    `CHK(p0_oe_o, 8'h00)
    tdone("port zero");
    // Wrong sources of the high byte are given inverted values
    for (int i = 0; i < 12; i++) begin
      k = access_kind_e'(i % 4);
      w = (i / 4 == 1) && k >= ACC_MOVE_PTR;
      ea = (i < 8) ? 16'($urandom) : eas[i - 4];
      eas[i] = ea;
      wr(8'h8E, (i < 4) ? 8'h02 : 8'h03);
      wr(8'hA0, ea[15:8] ^ {8{k != ACC_MOVE_RI}});
      wr(8'h82, ea[7:0]);
      wr(8'h83, ea[15:8] ^ {8{k != ACC_MOVE_PTR}});
      d = 8'($urandom);
      req(k, w, (k < ACC_MOVE_PTR) ? ea : ~ea, ea[7:0], d);
      `CHK(cap_lo, ea[7:0])
      `CHK(cap_oe, 8'hFF)
      `CHK(cap_p2, ea[15:8])
      `CHK({ps_s, rd_s, wr_s}, {k < ACC_MOVE_PTR, k >= ACC_MOVE_PTR && !w, w})
      if (w) sh[ea] = d;
      else `CHK(q, expd(ea))
      if (i >= 4) `CHK(ale_n, 1)
    end
    tdone("bus cycles");
    @(negedge clk_i);
    base = ale_n;
    repeat (60) @(negedge clk_i);
    `CHK(ale_n - base, 0)
    tdone("strobe idle");
    wr(8'h8E, 8'h01);
    wr(8'hA0, 8'h00);
    ea = {8'h00, 8'($urandom)};
    d = ~expd(ea);
    req(ACC_MOVE_RI, 1'b1, 16'h0000, ea[7:0], d);
    `CHK(n, 2)
    `CHK({rd_s, wr_s, ale_n == 0}, 3'b001)
    req(ACC_MOVE_RI, 1'b0, 16'h0000, ea[7:0], 8'h00);
    `CHK(q, d)
    wr(8'h8E, 8'h03);
    req(ACC_MOVE_RI, 1'b0, 16'h0000, ea[7:0], 8'h00);
    `CHK(q, expd(ea))
    tdone("ram select");
    wr(8'hA2, 8'h00);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    tog();
    wb(1'b0, 8'hA2, 8'h00);
    `CHK(q[0], 1'b1)
    wr(8'h82, 8'hCD);
    wr(8'h83, 8'hAB);
    @(negedge clk_i);
    `CHK(data_pointer_o, 16'hABCD)
    tog();
    @(negedge clk_i);
    `CHK(data_pointer_o, 16'h1234)
    wb(1'b0, 8'hA2, 8'h00);
    `CHK(q[0], 1'b0)
    tdone("pointer");
    wr(8'h10, 8'h5A);
    wb(1'b0, 8'h10, 8'h00);
    `CHK(q, 8'h00)
    tdone("unmapped");
    end_of_test();
  end
endmodule

// ===== design/ext_bus_pkg.sv
// Types shared by the external memory bus interface.
// Assumes nothing beyond a SystemVerilog compiler.
package ext_bus_pkg;

  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_CODE_TABLE,
    ACC_MOVE_PTR,
    ACC_MOVE_RI
  } access_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_HOLD,
    ST_DATA
  } bus_state_e;

endpackage

// ===== design/ext_bus_regs.svh
// Register indices, field positions, reset values and pin patterns of the external bus.
// Assumes a Wishbone byte address whose bits 9..2 carry the register index.
// Behaviour
// R1 - Port 0 carries low address, then data
// R2 - Bus ones on Port 0 driven strongly
// R3 - Port 0 as port is open drain
// R4 - Port 2 gives high address byte
// R5 - Register-indirect move puts Port 2 latch out
// R6 - Data moves strobe write or read pin
// R7 - Address strobe runs continuously when not suppressed
// R8 - Suppressed strobe pulses only on bus accesses
// R9 - Select bit routes low page on/off chip
// R10 - Stack never reaches expanded RAM
// R11 - Software writes zero to reserved bits
// R12 - Increment toggles the pointer select bit
// R13 - Latch captures low address on strobe fall
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

`define IDX_PORT0        8'h80
`define IDX_PTR_LO       8'h82
`define IDX_PTR_HI       8'h83
`define IDX_AUX          8'h8E
`define IDX_PORT2        8'hA0
`define IDX_DPC          8'hA2
`define IDX_SPEED        8'hC0
`define IDX_STATUS       8'hC1

`define WB_IDX_MSB       9
`define WB_IDX_LSB       2
`define WB_PAD           24'h000000

`define AUX_SUPPRESS_BIT 0
`define AUX_OFFCHIP_BIT  1
`define DPC_SELECT_BIT   0
`define SPEED_X2_BIT     0
`define STATUS_BUSY_BIT  0

`define BIT_CLEAR        1'b0
`define BYTE_ZERO        8'h00
`define LATCH_RESET      8'hFF
`define PTR_RESET        16'h0000
`define HIGH_PAGE_ZERO   8'h00
`define P0_ALL_DRIVEN    8'hFF
`define P0_FLOAT         8'h00

`endif

// ===== design/external_memory_bus_interface.sv
// External memory bus: multiplexed Port 0, Port 2 high address, strobes,
// expanded on-chip RAM and the dual data pointer, with a Wishbone register slave.
// Assumes the core holds one request at a time until done_o, on clk_i.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`include "ext_bus_regs.svh"

module external_memory_bus_interface (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [9:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       req_i,
  input  wire ext_bus_pkg::access_kind_e  req_kind_i,
  input  wire logic                       req_we_i,
  input  wire logic [15:0]                req_addr_i,
  input  wire logic [7:0]                 req_ri_i,
  input  wire logic [7:0]                 req_wdata_i,
  output logic                            done_o,
  output logic      [7:0]                 rdata_o,
  input  wire logic                       pointer_toggle_i,
  output logic      [15:0]                data_pointer_o,
  input  wire logic [7:0]                 p0_i,
  output logic      [7:0]                 p0_o,
  output logic      [7:0]                 p0_oe_o,
  output logic      [7:0]                 p2_o,
  output logic                            ale_o,
  output logic                            psen_n_o,
  output logic                            wr_n_o,
  output logic                            rd_n_o
);
  import ext_bus_pkg::*;

  function automatic logic is_move(input access_kind_e k);
    is_move = (k == ACC_MOVE_PTR) || (k == ACC_MOVE_RI);
  endfunction

  // Register file
  logic         wb_ack_r,    wb_ack_nxt;
  logic [31:0]  wb_dat_r,    wb_dat_nxt;
  logic [1:0]   aux_r,       aux_nxt;
  logic         dpc_sel_r,   dpc_sel_nxt;
  logic         x2_r,        x2_nxt;
  logic [7:0]   port0_r,     port0_nxt;
  logic [7:0]   port2_r,     port2_nxt;
  logic [15:0]  ptr0_r,      ptr0_nxt;
  logic [15:0]  ptr1_r,      ptr1_nxt;
  // Bus sequencer
  bus_state_e   state_r,     state_nxt;
  logic         ph_r,        ph_nxt;
  logic         op_vld_r,    op_vld_nxt;
  access_kind_e op_kind_r,   op_kind_nxt;
  logic         op_we_r,     op_we_nxt;
  logic [15:0]  op_addr_r,   op_addr_nxt;
  logic [7:0]   op_wdata_r,  op_wdata_nxt;
  logic         done_r,      done_nxt;
  logic [7:0]   rdata_r,     rdata_nxt;
  logic [1:0]   fin_r,       fin_nxt;
  // Pin synchroniser
  logic [7:0]   p0_meta_r;
  logic [7:0]   p0_sync_r;

  logic [7:0]   onchip_expanded_ram [0:255];
  logic [7:0]   onchip_expanded_ram_q;
  logic [7:0]   wb_idx;
  logic         wb_take;
  logic         wb_wr;
  logic         suppress;
  logic         offchip;
  logic         ph_en;
  logic [15:0]  active_ptr;
  logic [15:0]  eff_addr;
  logic         int_route;
  logic         int_hit;
  logic         ext_pending;
  logic         take;
  logic         slot_go;

  assign wb_idx     = wb_adr_i[`WB_IDX_MSB:`WB_IDX_LSB];
  assign wb_take    = wb_cyc_i && wb_stb_i && !wb_ack_r;
  assign wb_wr      = wb_cyc_i && wb_stb_i && wb_ack_r && wb_we_i && wb_sel_i[0];
  assign suppress   = aux_r[`AUX_SUPPRESS_BIT];
  assign offchip    = aux_r[`AUX_OFFCHIP_BIT];
  assign active_ptr = dpc_sel_r ? ptr1_r : ptr0_r;

  always_comb begin
    wb_ack_nxt  = wb_take;
    wb_dat_nxt  = wb_dat_r;
    aux_nxt     = aux_r;
    x2_nxt      = x2_r;
    port0_nxt   = port0_r;
    port2_nxt   = port2_r;
    ptr0_nxt    = ptr0_r;
    ptr1_nxt    = ptr1_r;
    dpc_sel_nxt = dpc_sel_r;
    if (wb_take && !wb_we_i) begin
      case (wb_idx)
        `IDX_PORT0:  wb_dat_nxt = {`WB_PAD, p0_sync_r};
        `IDX_PTR_LO: wb_dat_nxt = {`WB_PAD, active_ptr[7:0]};
        `IDX_PTR_HI: wb_dat_nxt = {`WB_PAD, active_ptr[15:8]};
        // Reserved bits read as zero; software must not rely on them [R11]
        `IDX_AUX:    wb_dat_nxt = {`WB_PAD, 6'h00, aux_r};
        `IDX_PORT2:  wb_dat_nxt = {`WB_PAD, port2_r};
        `IDX_DPC:    wb_dat_nxt = {`WB_PAD, 7'h00, dpc_sel_r};
        `IDX_SPEED:  wb_dat_nxt = {`WB_PAD, 7'h00, x2_r};
        `IDX_STATUS: wb_dat_nxt = {`WB_PAD, 7'h00, op_vld_r};
        default:     wb_dat_nxt = {`WB_PAD, `BYTE_ZERO};
      endcase
    end
    if (wb_wr) begin
      case (wb_idx)
        `IDX_PORT0:  port0_nxt = wb_dat_i[7:0];
        `IDX_PTR_LO: begin
          ptr0_nxt[7:0] = dpc_sel_r ? ptr0_r[7:0] : wb_dat_i[7:0];
          ptr1_nxt[7:0] = dpc_sel_r ? wb_dat_i[7:0] : ptr1_r[7:0];
        end
        `IDX_PTR_HI: begin
          ptr0_nxt[15:8] = dpc_sel_r ? ptr0_r[15:8] : wb_dat_i[7:0];
          ptr1_nxt[15:8] = dpc_sel_r ? wb_dat_i[7:0] : ptr1_r[15:8];
        end
        `IDX_AUX:    aux_nxt = wb_dat_i[1:0];
        `IDX_PORT2:  port2_nxt = wb_dat_i[7:0];
        `IDX_DPC:    dpc_sel_nxt = wb_dat_i[`DPC_SELECT_BIT];
        `IDX_SPEED:  x2_nxt = wb_dat_i[`SPEED_X2_BIT];
        default:     ;
      endcase
    end
    // Increment of the pointer register flips the select, even over a write [R12]
    dpc_sel_nxt = dpc_sel_nxt ^ pointer_toggle_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r  <= `BIT_CLEAR;
      wb_dat_r  <= {`WB_PAD, `BYTE_ZERO};
      aux_r     <= 2'h0;
      x2_r      <= `BIT_CLEAR;
      port0_r   <= `LATCH_RESET;
      port2_r   <= `LATCH_RESET;
      ptr0_r    <= `PTR_RESET;
      ptr1_r    <= `PTR_RESET;
      dpc_sel_r <= `BIT_CLEAR;
    end else begin
      wb_ack_r  <= wb_ack_nxt;
      wb_dat_r  <= wb_dat_nxt;
      aux_r     <= aux_nxt;
      x2_r      <= x2_nxt;
      port0_r   <= port0_nxt;
      port2_r   <= port2_nxt;
      ptr0_r    <= ptr0_nxt;
      ptr1_r    <= ptr1_nxt;
      dpc_sel_r <= dpc_sel_nxt;
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;

  // Only data moves, fetches and code-table reads arrive here; stack traffic stays in core RAM [R10]
  always_comb begin
    case (req_kind_i)
      ACC_MOVE_PTR: eff_addr = active_ptr;
      ACC_MOVE_RI:  eff_addr = {`HIGH_PAGE_ZERO, req_ri_i};
      default:      eff_addr = req_addr_i;
    endcase
  end

  // Low page of data moves goes on chip unless the off-chip select is set [R9]
  assign int_route   = is_move(req_kind_i) && (eff_addr[15:8] == `HIGH_PAGE_ZERO) && !offchip;
  assign int_hit     = req_i && !done_r && int_route && !op_vld_r && !(|fin_r);
  assign ext_pending = req_i && !done_r && !int_route && !(|fin_r);
  assign onchip_expanded_ram_q      = onchip_expanded_ram[eff_addr[7:0]];

  always_ff @(posedge clk_i) begin
    if (int_hit && req_we_i) begin
      onchip_expanded_ram[eff_addr[7:0]] <= req_wdata_i;
    end
  end

  // One state lasts two clocks, or one in double speed
  assign ph_en   = x2_r || ph_r;
  assign take    = ext_pending && !op_vld_r;
  // Free-running slots unless suppressed [R7] [R8]
  assign slot_go = !suppress || take;

  always_comb begin
    state_nxt    = state_r;
    ph_nxt       = x2_r ? `BIT_CLEAR : !ph_r;
    op_vld_nxt   = op_vld_r;
    op_kind_nxt  = op_kind_r;
    op_we_nxt    = op_we_r;
    op_addr_nxt  = op_addr_r;
    op_wdata_nxt = op_wdata_r;
    done_nxt     = `BIT_CLEAR;
    rdata_nxt    = rdata_r;
    fin_nxt      = {fin_r[0], `BIT_CLEAR}; // Synced pins trail the slot by two
    if (int_hit) begin
      done_nxt = 1'b1;
      if (!req_we_i) begin
        rdata_nxt = onchip_expanded_ram_q;
      end
    end
    if (fin_r[1]) begin
      done_nxt  = 1'b1;
      rdata_nxt = op_we_r ? rdata_r : p0_sync_r;
    end
    if (ph_en) begin
      case (state_r)
        ST_IDLE, ST_DATA: begin
          if (state_r == ST_DATA && op_vld_r) begin
            fin_nxt[0] = 1'b1;
            op_vld_nxt = `BIT_CLEAR;
          end
          if (slot_go) begin
            state_nxt = ST_ADDR;
            if (take) begin
              op_vld_nxt   = 1'b1;
              op_kind_nxt  = req_kind_i;
              op_we_nxt    = req_we_i && is_move(req_kind_i);
              op_addr_nxt  = eff_addr;
              op_wdata_nxt = req_wdata_i;
            end
          end else begin
            state_nxt = ST_IDLE;
          end
        end
        ST_ADDR: state_nxt = ST_HOLD;
        ST_HOLD: state_nxt = ST_DATA;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ST_IDLE;
      ph_r       <= `BIT_CLEAR;
      op_vld_r   <= `BIT_CLEAR;
      op_kind_r  <= ACC_FETCH;
      op_we_r    <= `BIT_CLEAR;
      op_addr_r  <= `PTR_RESET;
      op_wdata_r <= `BYTE_ZERO;
      done_r     <= `BIT_CLEAR;
      rdata_r    <= `BYTE_ZERO;
      fin_r      <= {`BIT_CLEAR, `BIT_CLEAR};
      p0_meta_r  <= `BYTE_ZERO;
      p0_sync_r  <= `BYTE_ZERO;
    end else begin
      state_r    <= state_nxt;
      ph_r       <= ph_nxt;
      op_vld_r   <= op_vld_nxt;
      op_kind_r  <= op_kind_nxt;
      op_we_r    <= op_we_nxt;
      op_addr_r  <= op_addr_nxt;
      op_wdata_r <= op_wdata_nxt;
      done_r     <= done_nxt;
      rdata_r    <= rdata_nxt;
      fin_r      <= fin_nxt;
      p0_meta_r  <= p0_i;
      p0_sync_r  <= p0_meta_r;
    end
  end

  assign done_o         = done_r;
  assign rdata_o        = rdata_r;
  assign data_pointer_o = active_ptr;

  // Pins are decoded from registered state only, so they never glitch on inputs
  always_comb begin
    if (op_vld_r && state_r != ST_DATA) begin
      p0_o    = op_addr_r[7:0];          // [R1]
      p0_oe_o = `P0_ALL_DRIVEN;          // [R2]
    end else if (op_vld_r && op_we_r) begin
      p0_o    = op_wdata_r;              // [R1]
      p0_oe_o = `P0_ALL_DRIVEN;          // [R2]
    end else if (op_vld_r) begin
      p0_o    = `BYTE_ZERO;
      p0_oe_o = `P0_FLOAT;
    end else begin
      // Open drain: a one releases the pin, which then reads as input [R3]
      p0_o    = `BYTE_ZERO;
      p0_oe_o = ~port0_r;
    end
  end

  // High address for fetches and pointer moves, latch for indirect moves [R4] [R5]
  assign p2_o     = (op_vld_r && op_kind_r != ACC_MOVE_RI) ? op_addr_r[15:8] : port2_r;
  // External latch takes Port 0 on the falling edge of this strobe [R13]
  assign ale_o    = (state_r == ST_ADDR);
  assign psen_n_o = !(op_vld_r && state_r == ST_DATA && !is_move(op_kind_r));
  assign wr_n_o   = !(op_vld_r && state_r == ST_DATA && is_move(op_kind_r) && op_we_r); // [R6]
  assign rd_n_o   = !(op_vld_r && state_r == ST_DATA && is_move(op_kind_r) && !op_we_r); // [R6]

  logic cfg_chg;
  assign cfg_chg = wb_wr && (wb_idx == `IDX_AUX || wb_idx == `IDX_SPEED);

  sequence s_wr_slot;
    $rose(ale_o) && op_vld_r && op_we_r && is_move(op_kind_r);
  endsequence
  sequence s_rd_slot;
    $rose(ale_o) && op_vld_r && !op_we_r && is_move(op_kind_r);
  endsequence

  property p_p0_mux;
    @(posedge clk_i) disable iff (rst_i)
    s_wr_slot |-> (p0_o == op_addr_r[7:0]) ##[2:4] (!wr_n_o && p0_o == op_wdata_r);
  endproperty
  a_p0_mux: assert property (p_p0_mux) else $error("port 0 not multiplexed"); // [R1]

  property p_p0_drive;
    @(posedge clk_i) disable iff (rst_i)
    op_vld_r && (state_r != ST_DATA || op_we_r) |-> p0_oe_o == `P0_ALL_DRIVEN;
  endproperty
  a_p0_drive: assert property (p_p0_drive) else $error("bus byte not driven"); // [R2]

  property p_p0_open;
    @(posedge clk_i) disable iff (rst_i)
    !op_vld_r |-> (p0_o == `BYTE_ZERO) && (p0_oe_o == ~port0_r);
  endproperty
  a_p0_open: assert property (p_p0_open) else $error("port 0 not open drain"); // [R3]

  property p_p2_high;
    @(posedge clk_i) disable iff (rst_i)
    $rose(op_vld_r) && op_kind_r != ACC_MOVE_RI |-> p2_o == op_addr_r[15:8] [*2];
  endproperty
  a_p2_high: assert property (p_p2_high) else $error("port 2 lacks high address"); // [R4]

  property p_p2_latch;
    @(posedge clk_i) disable iff (rst_i)
    op_vld_r && op_kind_r == ACC_MOVE_RI |-> p2_o == port2_r;
  endproperty
  a_p2_latch: assert property (p_p2_latch) else $error("port 2 latch not shown"); // [R5]

  property p_rd_strobe;
    @(posedge clk_i) disable iff (rst_i)
    s_rd_slot |-> rd_n_o && wr_n_o ##[2:4] (!rd_n_o && wr_n_o);
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing"); // [R6]

  property p_ale_rate;
    @(posedge clk_i) disable iff (rst_i || cfg_chg)
    $rose(ale_o) && !suppress && !cfg_chg |-> if (x2_r) ##3 $rose(ale_o) else ##6 $rose(ale_o);
  endproperty
  a_ale_rate: assert property (p_ale_rate) else $error("strobe rate wrong"); // [R7]

  property p_ale_quiet;
    @(posedge clk_i) disable iff (rst_i)
    ale_o && $past(suppress, 2) && $past(suppress) && suppress |-> op_vld_r;
  endproperty
  a_ale_quiet: assert property (p_ale_quiet) else $error("strobe while suppressed"); // [R8]

  property p_route;
    @(posedge clk_i) disable iff (rst_i)
    $rose(op_vld_r) && is_move(op_kind_r) |-> op_addr_r[15:8] != `HIGH_PAGE_ZERO || $past(offchip);
  endproperty
  a_route: assert property (p_route) else $error("low page left the chip"); // [R9]

  property p_toggle;
    @(posedge clk_i) disable iff (rst_i)
    pointer_toggle_i && !(wb_wr && wb_idx == `IDX_DPC) |=> dpc_sel_r != $past(dpc_sel_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("select bit not toggled"); // [R12]

endmodule
